// ---- hdl/mcs_core.sv ----
// four-phase instruction sequencer, data memory map, alu and flags of the 8-bit core
`timescale 1ns/10ps
`default_nettype none
`include "mcs_map.svh"

module mcs_core
   import mcs_pkg::*;
#(
   parameter logic [`MCS_PC_W-1:0] IRQ_VECTOR = `MCS_IRQ_VECTOR
) (
   input  wire logic                       clock,
   input  wire logic                       rstn,
   output logic [`MCS_PC_W-1:0]            prog_addr,
   input  wire logic [`MCS_WORD_W-1:0]     prog_data,
   output logic [`MCS_WORD_W-1:0]          exec_word,
   output logic                            exec_valid,
   output mcs_phase_type                   cycle_phase,
   input  wire mcs_kind_type               dec_kind,
   input  wire mcs_alu_fn_type             dec_fn,
   input  wire logic [`MCS_DADDR_W-1:0]    dec_addr,
   input  wire logic [7:0]                 dec_imm,
   input  wire logic                       dec_use_imm,
   input  wire logic                       dec_to_acc,
   input  wire logic                       dec_to_mem,
   input  wire logic                       dec_skip_on_zero,
   input  wire logic                       irq_ack,
   output logic                            irq_taken,
   input  wire logic                       dog_timeout,
   output logic                            powerdown_flag,
   output logic                            dog_expiry_flag
);

   // ------------------------------------------------------------
   // data memory decode
   // ------------------------------------------------------------
   function automatic logic [`MCS_DADDR_W-1:0] mcs_eff(input mcs_state_type s,
                                                       input logic [`MCS_DADDR_W-1:0] a);
      mcs_eff = (a == `MCS_ADDR_IND) ? s.ptr : a;
   endfunction : mcs_eff

   function automatic logic [7:0] mcs_read(input mcs_state_type s,
                                           input logic [`MCS_DADDR_W-1:0] a);
      logic [`MCS_DADDR_W-1:0] ea;
      ea = mcs_eff(s, a);
      case (ea)
         `MCS_ADDR_PTR:   mcs_read = {`MCS_PTR_TOP, s.ptr};
         `MCS_ADDR_ACC:   mcs_read = s.acc;
         `MCS_ADDR_PCL:   mcs_read = s.pc[7:0];
         `MCS_ADDR_LPTR:  mcs_read = s.lptr;
         `MCS_ADDR_LHI:   mcs_read = {2'h0, s.hi};
         `MCS_ADDR_FLAGS: mcs_read = {2'h0, s.flags};
         default: begin
            // pointer aimed at 00H lands here and reads zero
            if (ea >= `MCS_ADDR_RAM_LO && ea <= `MCS_ADDR_RAM_HI) begin
               mcs_read = s.ram[ea[4:0]];
            end else begin
               mcs_read = `MCS_BYTE_ZERO;
            end
         end
      endcase
   endfunction : mcs_read

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   mcs_state_type            s_q;
   mcs_state_type            s_d;
   logic                     exec_now;
   logic [7:0]               opa;
   logic [7:0]               opb;
   logic [7:0]               bx;
   logic [7:0]               bmask;
   logic                     cin;
   logic [4:0]               lo_sum;
   logic [7:0]               mid_sum;
   logic [8:0]               sum;
   logic [8:0]               adj;
   logic [7:0]               res;
   logic                     c_n;
   logic [3:0]               upd;
   logic                     wr_en;
   logic [`MCS_DADDR_W-1:0]  wr_addr;
   logic [7:0]               wr_data;
   logic [`MCS_DADDR_W-1:0]  wa;

   assign exec_now = (s_q.phase == MCS_PH4) && !s_q.flush && !s_q.tbl_pend;

   // ------------------------------------------------------------
   // alu
   // ------------------------------------------------------------
   always_comb begin
      opa   = s_q.acc;
      opb   = dec_use_imm ? dec_imm : mcs_read(s_q, dec_addr);
      bmask = 8'h01 << dec_imm[2:0];
      bx    = (dec_fn == MCS_F_SUB || dec_fn == MCS_F_SBC) ? ~opb : opb;
      case (dec_fn)
         MCS_F_SUB: cin = 1'b1;
         MCS_F_ADC,
         MCS_F_SBC: cin = s_q.flags[`MCS_FLG_C];
         default:   cin = 1'b0;
      endcase
      lo_sum  = {1'b0, opa[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
      mid_sum = {1'b0, opa[6:0]} + {1'b0, bx[6:0]} + {7'h00, cin};
      sum     = {1'b0, opa} + {1'b0, bx} + {8'h00, cin};
      adj     = {1'b0, opb};
      if (opb[3:0] > `MCS_NIBBLE_MAX || s_q.flags[`MCS_FLG_AC]) begin
         adj = 9'(adj + `MCS_DAA_LO);
      end
      if (adj[7:4] > `MCS_NIBBLE_MAX || adj[8] || s_q.flags[`MCS_FLG_C]) begin
         adj = 9'(adj + `MCS_DAA_HI);
      end
      res = opb;
      c_n = s_q.flags[`MCS_FLG_C];
      upd = 4'h0;
      case (dec_fn)
         MCS_F_ADD, MCS_F_ADC, MCS_F_SUB, MCS_F_SBC: begin
            res = sum[7:0];
            c_n = sum[8];
            upd = 4'hF;
         end
         MCS_F_DAA: begin
            res = adj[7:0];
            c_n = adj[8] | s_q.flags[`MCS_FLG_C];
            upd = 4'h1;
         end
         MCS_F_AND: begin
            res = opa & opb;
            upd = 4'h4;
         end
         MCS_F_OR: begin
            res = opa | opb;
            upd = 4'h4;
         end
         MCS_F_XOR: begin
            res = opa ^ opb;
            upd = 4'h4;
         end
         MCS_F_CPL: begin
            res = ~opb;
            upd = 4'h4;
         end
         MCS_F_RL:        res = {opb[6:0], opb[7]};
         MCS_F_RR:        res = {opb[0], opb[7:1]};
         MCS_F_RLC: begin
            res = {opb[6:0], s_q.flags[`MCS_FLG_C]};
            c_n = opb[7];
            upd = 4'h1;
         end
         MCS_F_RRC: begin
            res = {s_q.flags[`MCS_FLG_C], opb[7:1]};
            c_n = opb[0];
            upd = 4'h1;
         end
         MCS_F_INC: begin
            res = 8'(opb + 8'h01);
            upd = 4'h4;
         end
         MCS_F_DEC: begin
            res = 8'(opb - 8'h01);
            upd = 4'h4;
         end
         MCS_F_BIT_SET:   res = opb | bmask;
         MCS_F_BIT_CLEAR: res = opb & ~bmask;
         MCS_F_BIT_TEST:  res = opb & bmask;
         MCS_F_CLEAR:     res = `MCS_BYTE_ZERO;
         default:         res = opb;
      endcase
   end

   // ------------------------------------------------------------
   // sequencer and register file
   // ------------------------------------------------------------
   always_comb begin
      s_d           = s_q;
      s_d.irq_taken = 1'b0;
      wr_en         = 1'b0;
      wr_addr       = dec_addr;
      wr_data       = res;
      wa            = `MCS_ADDR_IND;
      case (s_q.phase)
         MCS_PH1: s_d.phase = MCS_PH2;
         MCS_PH2: s_d.phase = MCS_PH3;
         MCS_PH3: s_d.phase = MCS_PH4;
         MCS_PH4: s_d.phase = MCS_PH1;
         default: s_d.phase = MCS_PH1;
      endcase
      if (s_q.phase == MCS_PH4) begin
         if (s_q.tbl_pend) begin
            // second lookup cycle: the bus carried the table word, no fetch
            s_d.tbl_pend = 1'b0;
            s_d.hi       = prog_data[`MCS_WORD_W-1:8];
            wr_en        = 1'b1;
            wr_addr      = s_q.tbl_dest;
            wr_data      = prog_data[7:0];
         end else begin
            s_d.instr = prog_data;
            s_d.pc    = `MCS_PC_W'(s_q.pc + `MCS_PC_STEP);
            s_d.flush = 1'b0;
         end
         if (exec_now) begin
            case (dec_kind)
               MCS_K_ALU: begin
                  if (dec_to_acc) begin
                     s_d.acc = res;
                  end
                  wr_en = dec_to_mem;
                  if (upd[0]) s_d.flags[`MCS_FLG_C] = c_n;
                  if (upd[1]) s_d.flags[`MCS_FLG_AC] = lo_sum[4];
                  if (upd[2]) s_d.flags[`MCS_FLG_Z] = (res == `MCS_BYTE_ZERO);
                  if (upd[3]) s_d.flags[`MCS_FLG_OV] = mid_sum[7] ^ sum[8];
               end
               MCS_K_SKIP: begin
                  wr_en = dec_to_mem;
                  if ((res == `MCS_BYTE_ZERO) == dec_skip_on_zero) begin
                     s_d.flush = 1'b1;
                  end
               end
               MCS_K_JUMP: begin
                  s_d.pc    = s_q.instr[`MCS_PC_W-1:0];
                  s_d.flush = 1'b1;
               end
               MCS_K_CALL: begin
                  // a single level: an older return address is simply lost
                  s_d.stack = s_q.pc;
                  s_d.pc    = s_q.instr[`MCS_PC_W-1:0];
                  s_d.flush = 1'b1;
               end
               MCS_K_SUBROUTINE_EXIT, MCS_K_INTERRUPT_EXIT: begin
                  s_d.pc    = s_q.stack;
                  s_d.flush = 1'b1;
               end
               MCS_K_LOOKUP_CUR, MCS_K_LOOKUP_LAST: begin
                  s_d.tbl_pend = 1'b1;
                  s_d.tbl_dest = dec_addr;
                  s_d.tbl_addr = {(dec_kind == MCS_K_LOOKUP_LAST) ? `MCS_LAST_PAGE
                                                                  : s_q.pc[9:8],
                                  s_q.lptr};
               end
               MCS_K_WATCHDOG_CLEAR: begin
                  s_d.flags[`MCS_FLG_PD] = 1'b0;
                  s_d.flags[`MCS_FLG_TO] = 1'b0;
               end
               MCS_K_SLEEP: begin
                  s_d.flags[`MCS_FLG_PD] = 1'b1;
                  s_d.flags[`MCS_FLG_TO] = 1'b0;
               end
               default: s_d.flush = s_d.flush;
            endcase
         end
         if (wr_en) begin
            wa = mcs_eff(s_q, wr_addr);
            case (wa)
               `MCS_ADDR_PTR:   s_d.ptr = wr_data[`MCS_DADDR_W-1:0];
               `MCS_ADDR_ACC:   s_d.acc = wr_data;
               `MCS_ADDR_PCL: begin
                  s_d.pc    = {s_q.pc[9:8], wr_data};
                  s_d.flush = 1'b1;
               end
               `MCS_ADDR_LPTR:  s_d.lptr = wr_data;
               // explicit writes win over the alu's own flag update
               `MCS_ADDR_FLAGS: s_d.flags[`MCS_FLG_OV:`MCS_FLG_C] = wr_data[3:0];
               default: begin
                  if (wa >= `MCS_ADDR_RAM_LO && wa <= `MCS_ADDR_RAM_HI) begin
                     s_d.ram[wa[4:0]] = wr_data;
                  end
               end
            endcase
         end
         // interrupt only at a plain boundary; the requester holds irq_ack until taken
         if (irq_ack && exec_now && !s_d.flush && !s_d.tbl_pend) begin
            s_d.stack     = s_q.pc;
            s_d.pc        = IRQ_VECTOR;
            s_d.flush     = 1'b1;
            s_d.irq_taken = 1'b1;
         end
      end
      if (dog_timeout) begin
         s_d.flags[`MCS_FLG_TO] = 1'b1;
      end
      if (!rstn) begin
         s_d          = '0;
         s_d.phase    = MCS_PH1;
         s_d.pc       = `MCS_PC_RESET;
         s_d.flush    = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      s_q <= s_d;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prog_addr       = s_q.tbl_pend ? s_q.tbl_addr : s_q.pc;
   assign exec_word       = s_q.instr;
   assign exec_valid      = !s_q.flush && !s_q.tbl_pend;
   assign cycle_phase     = s_q.phase;
   assign irq_taken       = s_q.irq_taken;
   assign powerdown_flag  = s_q.flags[`MCS_FLG_PD];
   assign dog_expiry_flag = s_q.flags[`MCS_FLG_TO];

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   logic [7:0] ptr_view;
   logic [7:0] flag_view;
   logic       branch_now;
   logic       lookup_now;
   assign ptr_view   = mcs_read(s_q, `MCS_ADDR_PTR);
   assign flag_view  = mcs_read(s_q, `MCS_ADDR_FLAGS);
   assign branch_now = exec_now && (dec_kind == MCS_K_JUMP);
   assign lookup_now = exec_now && (dec_kind == MCS_K_LOOKUP_CUR || dec_kind == MCS_K_LOOKUP_LAST);

   sequence seq_phases;
      (s_q.phase == MCS_PH2) ##1 (s_q.phase == MCS_PH3) ##1 (s_q.phase == MCS_PH4)
      ##1 (s_q.phase == MCS_PH1);
   endsequence
   sequence seq_dummy_cycle;
      s_q.flush[*4] ##1 !s_q.flush;
   endsequence
   sequence seq_lookup_hold;
      s_q.tbl_pend[*4] ##1 !s_q.tbl_pend;
   endsequence

   phase_rotation_a: assert property (@(posedge clock) disable iff (!rstn)
      (s_q.phase == MCS_PH1) |=> seq_phases) else $error("phase sequence broken");
   counter_reset_a: assert property (@(posedge clock)
      $rose(rstn) |-> (s_q.pc == `MCS_PC_RESET)) else $error("counter not zero after reset");
   counter_step_a: assert property (@(posedge clock) disable iff (!rstn)
      (s_q.phase == MCS_PH4 && !s_q.tbl_pend && !s_d.flush)
      |=> (s_q.pc == 10'($past(s_q.pc) + 10'h001))) else $error("counter did not step");
   jump_dummy_a: assert property (@(posedge clock) disable iff (!rstn)
      branch_now |=> (s_q.pc == $past(s_q.instr[9:0])) and seq_dummy_cycle)
      else $error("jump target or dummy cycle wrong");
   lookup_two_a: assert property (@(posedge clock) disable iff (!rstn)
      lookup_now |=> seq_lookup_hold) else $error("lookup not two cycles");
   lookup_high_a: assert property (@(posedge clock) disable iff (!rstn)
      (s_q.tbl_pend && s_q.phase == MCS_PH4) |=> (s_q.hi == $past(prog_data[13:8])))
      else $error("lookup high byte not captured");
   pointer_top_a: assert property (@(posedge clock) disable iff (!rstn)
      ptr_view[7] && (ptr_view[6:0] == s_q.ptr)) else $error("pointer readback wrong");
   flag_top_a: assert property (@(posedge clock) disable iff (!rstn)
      flag_view[7:6] == 2'h0) else $error("flag bits 7..6 not zero");
   call_push_a: assert property (@(posedge clock) disable iff (!rstn)
      (exec_now && dec_kind == MCS_K_CALL) |=> (s_q.stack == $past(s_q.pc)))
      else $error("call did not push counter");
   sleep_flags_a: assert property (@(posedge clock) disable iff (!rstn)
      (exec_now && dec_kind == MCS_K_SLEEP && !dog_timeout)
      |=> powerdown_flag && !dog_expiry_flag) else $error("sleep flags wrong");
   skip_dummy_a: assert property (@(posedge clock) disable iff (!rstn)
      (exec_now && dec_kind == MCS_K_SKIP && ((res == `MCS_BYTE_ZERO) == dec_skip_on_zero))
      |=> seq_dummy_cycle) else $error("true skip did not insert a dummy cycle");
   flag_guard_a: assert property (@(posedge clock) disable iff (!rstn)
      (exec_now && dec_kind == MCS_K_ALU && dec_to_mem && dec_addr == `MCS_ADDR_FLAGS
       && !dog_timeout) |=> $stable(s_q.flags[`MCS_FLG_TO:`MCS_FLG_PD]))
      else $error("flag write touched power-down or expiry");

endmodule : mcs_core
`default_nettype wire

// ---- hdl/mcs_map.svh ----
// register offsets, field positions, reset values and widths of the core sequencer
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH

// ---------------------------------------------------------------
// widths and sizes
// ---------------------------------------------------------------
`define MCS_PC_W        10
`define MCS_WORD_W      14
`define MCS_DADDR_W     7
`define MCS_RAM_DEPTH   32
`define MCS_FLG_W       6
`define MCS_HI_W        6

// ---------------------------------------------------------------
// data memory map
// ---------------------------------------------------------------
`define MCS_ADDR_IND    7'h00
`define MCS_ADDR_PTR    7'h01
`define MCS_ADDR_ACC    7'h05
`define MCS_ADDR_PCL    7'h06
`define MCS_ADDR_LPTR   7'h07
`define MCS_ADDR_LHI    7'h08
`define MCS_ADDR_FLAGS  7'h0A
`define MCS_ADDR_RAM_LO 7'h20
`define MCS_ADDR_RAM_HI 7'h3F

// ---------------------------------------------------------------
// flag register bit positions
// ---------------------------------------------------------------
`define MCS_FLG_C       0
`define MCS_FLG_AC      1
`define MCS_FLG_Z       2
`define MCS_FLG_OV      3
`define MCS_FLG_PD      4
`define MCS_FLG_TO      5

// ---------------------------------------------------------------
// constant values
// ---------------------------------------------------------------
`define MCS_PC_RESET    10'h000
`define MCS_PC_STEP     10'h001
`define MCS_LAST_PAGE   2'h3
`define MCS_BYTE_ZERO   8'h00
`define MCS_PTR_TOP     1'b1
`define MCS_NIBBLE_MAX  4'h9
`define MCS_DAA_LO      9'h006
`define MCS_DAA_HI      9'h060
`define MCS_IRQ_VECTOR  10'h004

`endif

// ---- hdl/mcs_pkg.sv ----
// types shared by the core sequencer: phases, operation kinds, alu functions, state
`include "mcs_map.svh"

package mcs_pkg;

   // ------------------------------------------------------------
   // instruction cycle phases
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      MCS_PH1 = 4'b0001,
      MCS_PH2 = 4'b0010,
      MCS_PH3 = 4'b0100,
      MCS_PH4 = 4'b1000
   } mcs_phase_type;

   // ------------------------------------------------------------
   // decoded operation kinds and alu functions
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      MCS_K_NOP, MCS_K_ALU, MCS_K_SKIP, MCS_K_JUMP, MCS_K_CALL,
      MCS_K_SUBROUTINE_EXIT, MCS_K_INTERRUPT_EXIT,
      MCS_K_LOOKUP_CUR, MCS_K_LOOKUP_LAST, MCS_K_WATCHDOG_CLEAR, MCS_K_SLEEP
   } mcs_kind_type;

   typedef enum logic [4:0] {
      MCS_F_PASS, MCS_F_ADD, MCS_F_ADC, MCS_F_SUB, MCS_F_SBC, MCS_F_DAA,
      MCS_F_AND, MCS_F_OR, MCS_F_XOR, MCS_F_CPL, MCS_F_RL, MCS_F_RR,
      MCS_F_RLC, MCS_F_RRC, MCS_F_INC, MCS_F_DEC, MCS_F_BIT_SET,
      MCS_F_BIT_CLEAR, MCS_F_BIT_TEST, MCS_F_CLEAR
   } mcs_alu_fn_type;

   // ------------------------------------------------------------
   // complete core state
   // ------------------------------------------------------------
   typedef struct packed {
      mcs_phase_type                               phase;
      logic [`MCS_PC_W-1:0]                        pc;
      logic [`MCS_WORD_W-1:0]                      instr;
      logic                                        flush;
      logic                                        tbl_pend;
      logic [`MCS_PC_W-1:0]                        tbl_addr;
      logic [`MCS_DADDR_W-1:0]                     tbl_dest;
      logic [`MCS_PC_W-1:0]                        stack;
      logic [7:0]                                  acc;
      logic [`MCS_DADDR_W-1:0]                     ptr;
      logic [7:0]                                  lptr;
      logic [`MCS_HI_W-1:0]                        hi;
      logic [`MCS_FLG_W-1:0]                       flags;
      logic [`MCS_RAM_DEPTH-1:0][7:0]              ram;
      logic                                        irq_taken;
   } mcs_state_type;

endpackage : mcs_pkg

// ---- tb/mcs_prog_mem.sv ----
// program memory model answering the fetch address without delay
`timescale 1ns/10ps
`default_nettype none
module mcs_prog_mem (
   input  wire logic [9:0]  prog_addr,
   output logic [13:0]      prog_data
);
   // ------------------------------------------------------------
   // contents: low bits give page-crossing jump targets
   // ------------------------------------------------------------
   function automatic logic [13:0] word_at(input logic [9:0] a);
      return {a[3:0], a ^ 10'h3A5};
   endfunction : word_at
   assign prog_data = word_at(prog_addr);
endmodule : mcs_prog_mem
`default_nettype wire

// ---- tb/test_mcu_core_sequencer.sv ----
// self-checking bench of the core sequencer against a program memory model
`timescale 1ns/10ps
`default_nettype none
`include "mcs_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module test_mcu_core_sequencer;
   import mcs_pkg::*;
   logic clock, rstn, dec_use_imm, dec_to_acc, dec_to_mem, dec_skip_on_zero, irq_ack;
   logic dog_timeout, exec_valid, irq_taken, powerdown_flag, dog_expiry_flag;
   logic [9:0] prog_addr, cur_pc;
   logic [13:0] prog_data, exec_word, w;
   logic [6:0] dec_addr;
   logic [7:0] dec_imm;
   logic [1:0] pg;
   mcs_phase_type cycle_phase;
   mcs_kind_type dec_kind;
   mcs_alu_fn_type dec_fn;
   int fails, check_count, cycles;
   mcs_prog_mem mem (.prog_addr(prog_addr), .prog_data(prog_data));
   mcs_core DUT (.clock(clock), .rstn(rstn), .prog_addr(prog_addr), .prog_data(prog_data),
      .exec_word(exec_word), .exec_valid(exec_valid), .cycle_phase(cycle_phase),
      .dec_kind(dec_kind), .dec_fn(dec_fn), .dec_addr(dec_addr), .dec_imm(dec_imm),
      .dec_use_imm(dec_use_imm), .dec_to_acc(dec_to_acc), .dec_to_mem(dec_to_mem),
      .dec_skip_on_zero(dec_skip_on_zero), .irq_ack(irq_ack), .irq_taken(irq_taken),
      .dog_timeout(dog_timeout), .powerdown_flag(powerdown_flag),
      .dog_expiry_flag(dog_expiry_flag));
   always #5 clock = ~clock;
   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   // decode is presented at phase 3 so it is settled well before the commit edge
   task automatic op(input mcs_kind_type k, input mcs_alu_fn_type f, input logic [6:0] a,
                     input logic [7:0] i, input logic ui, input logic ta, input logic tm);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (!(cycle_phase === MCS_PH2 && exec_valid === 1'b1) && n < 64);
      cur_pc = prog_addr;
      @(posedge clock);
      dec_kind <= k;
      dec_fn <= f;
      dec_addr <= a;
      dec_imm <= i;
      dec_use_imm <= ui;
      dec_to_acc <= ta;
      dec_to_mem <= tm;
      repeat (2) @(posedge clock);
      dec_kind <= MCS_K_NOP;
      #1;
   endtask : op
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      op(MCS_K_ALU, MCS_F_PASS, a, v, 1'b1, 1'b0, 1'b1);
   endtask : wr
   // a value is seen through a skip: equal means the next word is dropped
   task automatic expect_mem(input logic [6:0] a, input logic [7:0] v);
      op(MCS_K_ALU, MCS_F_PASS, a, 8'h00, 1'b0, 1'b1, 1'b0);
      op(MCS_K_SKIP, MCS_F_XOR, a, v, 1'b1, 1'b0, 1'b0);
      `CHK(exec_valid, 1'b0)
   endtask : expect_mem
   // unary ops work on the memory operand, binary ones combine it with the accumulator
   task automatic alu_sweep;
      mcs_alu_fn_type fn [16] = '{MCS_F_ADC, MCS_F_SBC, MCS_F_DAA, MCS_F_AND, MCS_F_OR,
         MCS_F_CPL, MCS_F_RL, MCS_F_RR, MCS_F_RLC, MCS_F_RRC, MCS_F_INC, MCS_F_DEC,
         MCS_F_BIT_CLEAR, MCS_F_BIT_SET, MCS_F_CLEAR, MCS_F_BIT_TEST};
      logic [15:0] want [16] = '{16'hD102, 16'hA60A, 16'h9B02, 16'h1402, 16'hBD02,
         16'h6A02, 16'h2B02, 16'hCA02, 16'h2A03, 16'h4A03, 16'h9602, 16'h9402,
         16'h8502, 16'hB502, 16'h0002, 16'h8002};
      wr(7'h24, 8'h95);
      for (int i = 0; i < 16; i++) begin
         // carry clear, half carry set before every op; the index's low three bits give the bit number
         wr(7'h0A, 8'h02);
         op(MCS_K_ALU, MCS_F_PASS, 7'h00, 8'h3C, 1'b1, 1'b1, 1'b0);
         op(MCS_K_ALU, fn[i], 7'h24, 8'(i), 1'b0, 1'b1, 1'b0);
         expect_mem(7'h05, want[i][15:8]);
         expect_mem(7'h0A, want[i][7:0]);
      end
   endtask : alu_sweep
   // the request is held until taken; the exit must come back to the pushed counter
   task automatic irq_round_trip;
      int n;
      logic [9:0] ret;
      n = 0;
      ret = '0;
      @(posedge clock);
      irq_ack <= 1'b1;
      do begin
         ret = prog_addr;
         @(posedge clock);
         #1;
         n++;
      end while (irq_taken !== 1'b1 && n < 16);
      `CHK(irq_taken, 1'b1)
      `CHK(prog_addr, `MCS_IRQ_VECTOR)
      @(posedge clock);
      irq_ack <= 1'b0;
      #1;
      `CHK(irq_taken, 1'b0)
      op(MCS_K_INTERRUPT_EXIT, MCS_F_PASS, 7'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      `CHK(prog_addr, ret)
   endtask : irq_round_trip
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   always @(posedge clock) begin
      cycles++;
      if (cycles == 8000) begin
         fails++;
         report_and_stop();
      end
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      clock = 0; rstn = 0; dec_kind = MCS_K_NOP; dec_fn = MCS_F_PASS; dec_addr = 0;
      dec_imm = 0; dec_use_imm = 0; dec_to_acc = 0; dec_to_mem = 0; dec_skip_on_zero = 1;
      irq_ack = 0; dog_timeout = 0; fails = 0; check_count = 0; cycles = 0;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      #1;
      `CHK(prog_addr, 10'h000)
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         #1;
         `CHK(cycle_phase, 4'(4'b0001 << ((i + 1) % 4)))
      end
      `CHK(prog_addr, 10'h002)
      `CHK(exec_word, mem.word_at(10'h001))
      wr(7'h20, 8'h5A);
      expect_mem(7'h20, 8'h5A);
      wr(7'h03, 8'h77);
      expect_mem(7'h03, 8'h00);
      wr(7'h01, 8'h20);
      expect_mem(7'h01, 8'hA0);
      expect_mem(7'h00, 8'h5A);
      wr(7'h00, 8'h3C);
      expect_mem(7'h20, 8'h3C);
      wr(7'h01, 8'h00);
      wr(7'h00, 8'h99);
      expect_mem(7'h00, 8'h00);
      wr(7'h05, 8'h66);
      expect_mem(7'h05, 8'h66);
      op(MCS_K_SKIP, MCS_F_XOR, 7'h00, 8'h67, 1'b1, 1'b0, 1'b0);
      `CHK(exec_valid, 1'b1)
      @(posedge clock);
      dec_skip_on_zero <= 1'b0;
      op(MCS_K_SKIP, MCS_F_XOR, 7'h00, 8'h67, 1'b1, 1'b0, 1'b0);
      `CHK(exec_valid, 1'b0)
      `CHK(prog_addr, 10'(cur_pc + 10'h001))
      @(posedge clock);
      dec_skip_on_zero <= 1'b1;
      // carry, half carry, zero and wrap from add and subtract
      for (int j = 0; j < 3; j++) begin
         op(MCS_K_ALU, MCS_F_PASS, 7'h00, j == 2 ? 8'h10 : {j[0], 7'h7F}, 1'b1, 1'b1, 1'b0);
         op(MCS_K_ALU, j == 2 ? MCS_F_SUB : MCS_F_ADD, 7'h22, 8'h01, 1'b1, 1'b0, 1'b1);
         expect_mem(7'h0A, j == 0 ? 8'h0A : j == 1 ? 8'h07 : 8'h01);
         expect_mem(7'h22, j == 0 ? 8'h80 : j == 1 ? 8'h00 : 8'h0F);
      end
      alu_sweep();
      wr(7'h0A, 8'hFF);
      expect_mem(7'h0A, 8'h0F);
      wr(7'h07, 8'h12);
      for (int j = 0; j < 2; j++) begin
         op(j ? MCS_K_LOOKUP_LAST : MCS_K_LOOKUP_CUR, MCS_F_PASS, 7'h21, 8'h00, 0, 0, 0);
         pg = j ? 2'b11 : cur_pc[9:8];
         w = mem.word_at({pg, 8'h12});
         `CHK(exec_valid, 1'b0)
         `CHK(prog_addr, {pg, 8'h12})
         expect_mem(7'h21, w[7:0]);
         expect_mem(7'h08, {2'b00, w[13:8]});
      end
      op(MCS_K_JUMP, MCS_F_PASS, 7'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      `CHK(exec_valid, 1'b0)
      `CHK(prog_addr, mem.word_at(cur_pc - 10'h001) & 14'h03FF)
      op(MCS_K_CALL, MCS_F_PASS, 7'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      `CHK(prog_addr, mem.word_at(cur_pc - 10'h001) & 14'h03FF)
      op(MCS_K_CALL, MCS_F_PASS, 7'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      w = {4'h0, cur_pc};
      op(MCS_K_SUBROUTINE_EXIT, MCS_F_PASS, 7'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      `CHK(prog_addr, w[9:0])
      wr(7'h06, 8'h40);
      `CHK(prog_addr, {cur_pc[9:8], 8'h40})
      irq_round_trip();
      @(posedge clock);
      dog_timeout <= 1'b1;
      @(posedge clock);
      dog_timeout <= 1'b0;
      wr(7'h0A, 8'h00);
      `CHK(dog_expiry_flag, 1'b1)
      expect_mem(7'h0A, 8'h20);
      op(MCS_K_SLEEP, MCS_F_PASS, 7'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      `CHK({powerdown_flag, dog_expiry_flag}, 2'b10)
      op(MCS_K_WATCHDOG_CLEAR, MCS_F_PASS, 7'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      `CHK({powerdown_flag, dog_expiry_flag}, 2'b00)
      report_and_stop();
   end
endmodule : test_mcu_core_sequencer
`default_nettype wire
